// file: design/curtain_cfg.svh
`ifndef CURTAIN_CFG_SVH
`define CURTAIN_CFG_SVH
// ************************************************************
// register map (byte addresses)
// ************************************************************
`define OFS_CTRL      12'h000
`define OFS_MISMATCH  12'h004
`define OFS_SYNC      12'h008
`define OFS_MUTE      12'h00c
`define OFS_OVR       12'h010
`define OFS_STATUS    12'h014
`define OFS_DIAG      12'h018
// ************************************************************
// control fields
// ************************************************************
`define CTRL_ARR_LSB  0
`define CTRL_MAN_BIT  2
`define CTRL_SUP_BIT  3
// ************************************************************
// reset values, times in ms at a 1 ms scan tick
// ************************************************************
`define RST_CTRL      32'h0000_0004
`define RST_MISMATCH  32'h0000_01f4
`define RST_SYNC      32'h0000_03e8
`define RST_MUTE      32'h0000_ea60
`define RST_OVR       32'h0000_ea60
`define SCAN_US       1000
`define CLK_MHZ       20
`define SCAN_CYCLES   (`SCAN_US * `CLK_MHZ)
// ************************************************************
// diagnostic codes
// ************************************************************
`define DG_FREE       16'h8006
`define DG_MUTE       16'h8018
`define DG_MISMATCH   16'hf001
`define DG_MUTE_TO    16'hf003
`define DG_SYNC_TO    16'hf004
`define DG_OVR_TO     16'hf005
`define DG_SEQ        16'hf019
`define DG_IDLE       16'h2003
`endif

// file: design/curtain_pkg.sv
package curtain_pkg;
   // muting sensor arrangement
   typedef enum logic [1:0] {
      parallel_two_sensor,
      parallel_four_sensor,
      sequential_two_sensor,
      sequential_four_sensor
   } arrangement_t;
   // sampled field inputs
   typedef struct packed {
      logic curtain_ch_one;
      logic curtain_ch_two;
      logic sensor_grp_a_first;
      logic sensor_grp_a_second;
      logic sensor_grp_b_first;
      logic sensor_grp_b_second;
      logic bypass_override_input;
      logic restart_input;
   } field_in_t;
   // latched errors
   typedef struct packed {
      logic seq;
      logic ovr_to;
      logic mute_to;
      logic sync_to;
      logic mismatch;
   } err_t;
endpackage

// file: design/light_curtain_muting_monitor.sv
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
`include "curtain_cfg.svh"
module light_curtain_muting_monitor #(
   parameter int unsigned SCAN_CYCLES = `SCAN_CYCLES
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  clk_en,
   // field inputs
   input  wire curtain_pkg::field_in_t field_in,
   input  wire logic                  block_activate,
   // field outputs
   output logic                       release_output,
   output logic                       bypass_indicator,
   output logic                       fault_output,
   // axi4-lite write address
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);
   // ************************************************************
   // registers
   // ************************************************************
   logic [31:0]               ctrl_q;         // arrangement and restart mode
   logic [31:0]               mism_q;         // channel_mismatch_limit
   logic [31:0]               sync_q;         // sync_window
   logic [31:0]               mute_lim_q;     // mute_time_limit
   logic [31:0]               ovr_lim_q;      // override_window, zero disables
   curtain_pkg::field_in_t    in_q;           // scan-sampled inputs
   curtain_pkg::err_t         err_q;          // latched errors
   logic                      muting_q;       // muting phase active
   logic                      ovr_q;          // override active
   logic                      armed_q;        // restart given
   logic                      seq_b_q;        // four seq: direction b to a
   logic                      seq_stage_q;    // four seq: second group reached
   logic [31:0]               mis_t_q;        // discrepancy timer
   logic [31:0]               syn_t_q;        // sync timer
   logic [31:0]               mut_t_q;        // muting timer
   logic [31:0]               ovr_t_q;        // override timer
   logic [31:0]               scan_q;         // scan prescaler
   logic [15:0]               diag_q;         // diagnostic code
   logic                      aw_hold_q;      // write address taken
   logic                      w_hold_q;       // write data taken
   logic [11:0]               awaddr_q;       // held write address
   logic [31:0]               wdata_q;        // held write data
   logic [3:0]                wstrb_q;        // held strobes
   // ************************************************************
   // decode
   // ************************************************************
   wire                        tick   = clk_en && (scan_q == SCAN_CYCLES - 1);
   curtain_pkg::arrangement_t  arr;
   assign arr = curtain_pkg::arrangement_t'(ctrl_q[`CTRL_ARR_LSB +: 2]);
   wire manual  = ctrl_q[`CTRL_MAN_BIT] || ctrl_q[`CTRL_SUP_BIT];
   wire ch1 = in_q.curtain_ch_one;
   wire ch2 = in_q.curtain_ch_two;
   wire a1 = in_q.sensor_grp_a_first;
   wire a2 = in_q.sensor_grp_a_second;
   wire b1 = in_q.sensor_grp_b_first;
   wire b2 = in_q.sensor_grp_b_second;
   wire four   = (arr == curtain_pkg::parallel_four_sensor) ||
                 (arr == curtain_pkg::sequential_four_sensor);
   wire clear  = ch1 && ch2;                       // beams unbroken
   wire ch_off = !ch1 && !ch2;                      // both channels dropped
   wire ch_mis = ch1 ^ ch2;
   wire grp_a  = a1 && a2;
   wire grp_b  = b1 && b2;
   wire any_a  = a1 || a2;
   wire any_b  = b1 || b2;
   wire no_sen = !any_a && !any_b;
   wire sync_pend = four ? ((any_a && !grp_a) || (any_b && !grp_b))
                         : (any_a && !grp_a);
   wire par2 = arr == curtain_pkg::parallel_two_sensor;
   wire par4 = arr == curtain_pkg::parallel_four_sensor;
   wire seq2 = arr == curtain_pkg::sequential_two_sensor;
   wire seq4 = arr == curtain_pkg::sequential_four_sensor;
   // muting start condition per arrangement
   wire start_p2 = par2 && grp_a;
   wire start_p4 = par4 && (grp_a || grp_b);
   wire start_s2 = seq2 && grp_a;
   wire start_s4 = seq4 && ((a1 && a2 && !any_b) || (b2 && b1 && !any_a));
   wire mute_start = start_p2 || start_p4 || start_s2 || start_s4;
   // wrong order in two-sequential: second before first
   wire bad_s2 = seq2 && !muting_q && a2 && !a1;
   // four-sequential order check
   wire bad_s4 = seq4 && (!muting_q ? ((a2 && !a1 && !any_b) || (b1 && !b2 && !any_a)
                                       || (any_a && any_b))
                                    : (seq_b_q ? (a1 && !a2) : (b2 && !b1)));
   // end of muting
   wire mute_end = muting_q && (four ? (no_sen && clear)
                                     : (seq2 ? (!grp_a && clear) : (no_sen && clear)));
   wire err_any  = |err_q;
   wire ovr_ok   = err_q.seq && (ovr_lim_q != 32'h0);
   wire dflt     = no_sen && clear;
   // ************************************************************
   // scan prescaler
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         scan_q <= 32'h0;
      else if (clk_en)
         scan_q <= tick ? 32'h0 : scan_q + 32'h1;
   end
   // ************************************************************
   // input sampling once per scan
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         in_q <= '0;
      else if (tick)
         in_q <= field_in;
   end
   // ************************************************************
   // timers, count scans while their condition stands
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mis_t_q <= 32'h0;
         syn_t_q <= 32'h0;
         mut_t_q <= 32'h0;
         ovr_t_q <= 32'h0;
      end
      else if (tick)
      begin
         mis_t_q <= ch_mis ? mis_t_q + 32'h1 : 32'h0;
         syn_t_q <= (sync_pend && !muting_q) ? syn_t_q + 32'h1 : 32'h0;
         mut_t_q <= muting_q ? mut_t_q + 32'h1 : 32'h0;
         ovr_t_q <= ovr_q ? ovr_t_q + 32'h1 : 32'h0;
      end
   end
   // ************************************************************
   // error latches, set wins over acknowledge
   // ************************************************************
   wire set_mis = ch_mis && (mis_t_q >= mism_q);
   wire set_syn = (par2 || par4) && sync_pend && !muting_q && (syn_t_q >= sync_q);
   wire set_mut = muting_q && (mut_t_q >= mute_lim_q);
   wire set_ovr = ovr_q && (ovr_t_q >= ovr_lim_q);
   wire set_seq = bad_s2 || bad_s4;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         err_q <= '0;
      else if (tick && block_activate)
      begin
         err_q.mismatch <= set_mis || (err_q.mismatch && !ch_off);
         err_q.sync_to  <= set_syn || (err_q.sync_to && !no_sen);
         err_q.mute_to  <= set_mut || (err_q.mute_to && !(ch_off && no_sen));
         err_q.ovr_to   <= set_ovr || (err_q.ovr_to && !(ch_off && no_sen));
         err_q.seq      <= set_seq || (err_q.seq &&
                           in_q.bypass_override_input && !in_q.restart_input);
      end
   end
   // ************************************************************
   // muting, override and restart state
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         muting_q    <= 1'b0;
         ovr_q       <= 1'b0;
         armed_q     <= 1'b0;
         seq_b_q     <= 1'b0;
         seq_stage_q <= 1'b0;
      end
      else if (tick)
      begin
         if (!block_activate || err_any || mute_end)
            muting_q <= 1'b0;
         else if (!muting_q && mute_start && clear)
            muting_q <= 1'b1;
         if (!muting_q && mute_start)
            seq_b_q <= any_b;
         seq_stage_q <= muting_q && (seq_b_q ? any_a : any_b);
         if (!ovr_q)
            ovr_q <= ovr_ok && in_q.bypass_override_input;
         else if (set_ovr || !in_q.bypass_override_input || dflt)
            ovr_q <= 1'b0;
         if (!clear && !muting_q && !ovr_q)
            armed_q <= !manual;
         else if (err_any && !ovr_q)
            armed_q <= 1'b0;
         else if (ovr_q && dflt)
            armed_q <= !manual;
         else if (!armed_q && clear && !err_any)
            armed_q <= !manual || in_q.restart_input;
      end
   end
   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         release_output   <= 1'b0;
         bypass_indicator <= 1'b0;
         fault_output     <= 1'b0;
         diag_q           <= `DG_IDLE;
      end
      else if (tick)
      begin
         release_output   <= block_activate && (ovr_q ||
                             (!err_any && armed_q && (clear || muting_q)));
         bypass_indicator <= block_activate && muting_q;
         fault_output     <= block_activate && err_any;
         diag_q           <= err_q.mute_to  ? `DG_MUTE_TO :
                             err_q.mismatch ? `DG_MISMATCH :
                             err_q.sync_to  ? `DG_SYNC_TO :
                             err_q.ovr_to   ? `DG_OVR_TO :
                             err_q.seq      ? `DG_SEQ :
                             muting_q       ? `DG_MUTE :
                             armed_q        ? `DG_FREE : `DG_IDLE;
      end
   end
   // ************************************************************
   // axi4-lite slave, one cycle answer after both channels taken
   // ************************************************************
   wire        wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;
   wire [11:0] rd_a  = s_axi_araddr;
   wire        wr_ok = awaddr_q <= `OFS_OVR;
   wire [31:0] st_w  = {20'h0, seq_stage_q, ovr_q, muting_q, armed_q, 3'h0, err_q};
   wire [31:0] rd_v  = (rd_a == `OFS_CTRL)     ? ctrl_q :
                       (rd_a == `OFS_MISMATCH) ? mism_q :
                       (rd_a == `OFS_SYNC)     ? sync_q :
                       (rd_a == `OFS_MUTE)     ? mute_lim_q :
                       (rd_a == `OFS_OVR)      ? ovr_lim_q :
                       (rd_a == `OFS_STATUS)   ? st_w :
                       (rd_a == `OFS_DIAG)     ? {16'h0, diag_q} : 32'h0;
   wire        rd_ok = rd_a <= `OFS_DIAG && rd_a[1:0] == 2'b00;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         if (be[i]) old[8*i +: 8] = nw[8*i +: 8];
      return old;
   endfunction
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0; w_hold_q <= 1'b0; s_axi_bvalid <= 1'b0; s_axi_rvalid <= 1'b0;
         s_axi_bresp <= 2'b00; s_axi_rresp <= 2'b00; s_axi_rdata <= 32'h0;
         awaddr_q <= 12'h0; wdata_q <= 32'h0; wstrb_q <= 4'h0;
         ctrl_q <= `RST_CTRL; mism_q <= `RST_MISMATCH; sync_q <= `RST_SYNC;
         mute_lim_q <= `RST_MUTE; ovr_lim_q <= `RST_OVR;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready) begin aw_hold_q <= 1'b1; awaddr_q <= s_axi_awaddr; end
         if (s_axi_wvalid && s_axi_wready) begin w_hold_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb; end
         if (wr_go)
         begin
            aw_hold_q <= 1'b0; w_hold_q <= 1'b0; s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            case (awaddr_q)
               `OFS_CTRL:     ctrl_q     <= merge(ctrl_q, wdata_q, wstrb_q);
               `OFS_MISMATCH: mism_q     <= merge(mism_q, wdata_q, wstrb_q);
               `OFS_SYNC:     sync_q     <= merge(sync_q, wdata_q, wstrb_q);
               `OFS_MUTE:     mute_lim_q <= merge(mute_lim_q, wdata_q, wstrb_q);
               `OFS_OVR:      ovr_lim_q  <= merge(ovr_lim_q, wdata_q, wstrb_q);
               default: ;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_v; s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= clk_en && !aw_hold_q && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= clk_en && !w_hold_q && !(s_axi_wvalid && s_axi_wready);
         s_axi_arready <= clk_en && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end
   // ************************************************************
   // checks
   // ************************************************************
   a_release_fault_excl: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && block_activate && err_any && !ovr_q) |=> !release_output)
      else $error("release with fault");
   a_mute_timeout_fault: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && block_activate && set_mut) |=> err_q.mute_to) else $error("mute timeout lost");
   a_mute_diag_code: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && err_q.mute_to) |=> diag_q == 16'hf003) else $error("wrong diag");
   a_indicator_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && block_activate && muting_q) |=> bypass_indicator) else $error("no indicator");
   a_curtain_break_opens: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && ch_off && !muting_q && !ovr_q) |=> !release_output) else $error("release held");
   a_override_needs_err: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && !ovr_q && !ovr_ok) |=> !ovr_q) else $error("override w/o error");
   a_override_drop_ends: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && ovr_q && !in_q.bypass_override_input) |=> !ovr_q) else $error("override kept");
   a_inactive_no_fault: assert property (@(posedge aclk) disable iff (!aresetn)
      (tick && !block_activate) |=> !fault_output && !release_output) else $error("inactive");
   c_muting_seen: cover property (@(posedge aclk) bypass_indicator);
   c_override_seen: cover property (@(posedge aclk) ovr_q && release_output);
   c_mute_timeout: cover property (@(posedge aclk) err_q.mute_to);
endmodule // light_curtain_muting_monitor

// file: testbench/field_model.sv
`timescale 1ns/1ns
// ************************************
// field side: curtain, sensors, keys
// ************************************
module field_model (
   // clock
   input  wire logic              aclk,
   // levels asked for by the scenario
   input  wire logic [5:0]        lvl,
   input  wire logic              ovr,
   input  wire logic              press,
   // wiring into the block
   output curtain_pkg::field_in_t field_in
);
   // contacts move just after an edge; operator restart key
   always_ff @(posedge aclk)
      field_in <= {lvl, ovr, press};
endmodule // field_model

// file: testbench/light_curtain_muting_monitor_tb_top.sv
`timescale 1ns/1ns
module light_curtain_muting_monitor_tb_top;
   // ************************************
   // signals
   // ************************************
   logic                   aclk, aresetn, block_activate, ovr, press;
   logic [5:0]             lvl;          // ch1 ch2 a1 a2 b1 b2
   curtain_pkg::field_in_t field_in;
   logic                   release_output, bypass_indicator, fault_output;
   logic [2:0]             outs;
   logic [11:0]            s_axi_awaddr, s_axi_araddr;
   logic [31:0]            s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]             s_axi_bresp, s_axi_rresp, rr;
   logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                   s_axi_rvalid, s_axi_rready;
   int                     n_mismatch = 0;
   int                     n_compared = 0;
   int                     cyc = 0;
   string                  nm [3] = '{"release", "bypass", "fault"};
   assign outs = {fault_output, bypass_indicator, release_output};
   light_curtain_muting_monitor #(.SCAN_CYCLES(4)) DUT (
      .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .field_in(field_in),
      .block_activate(block_activate), .release_output(release_output),
      .bypass_indicator(bypass_indicator), .fault_output(fault_output),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   field_model fm (.aclk(aclk), .lvl(lvl), .ovr(ovr), .press(press), .field_in(field_in));
   // ************************************
   // clock, watchdog, shared tasks
   // ************************************
   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // cut a hang short
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test;
      end
   end
   task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] v);
      n_compared++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", s, e, v);
      end
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic rdr(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // wait up to lim cycles for an output, then judge it
   task automatic chk(input int i, input logic e, input int lim);
      int k;
      k = 0;
      while (outs[i] !== e && k < lim)
      begin
         @(posedge aclk);
         k++;
      end
      cmp(nm[i], {31'h0, e}, {31'h0, outs[i]});
   endtask
   // four scans covers the output latency
   task automatic stay(input int i, input logic e);
      repeat (16) @(posedge aclk);
      chk(i, e, 0);
   endtask
   // clear field, restart key, release must close
   task automatic rearm(input string t);
      lvl <= 6'b110000;
      press <= 1'b1;
      repeat (16) @(posedge aclk);
      press <= 1'b0;
      chk(0, 1'b1, 200);
      chk(2, 1'b0, 0);
      $display("test %s done", t);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ************************************
   // scenarios
   // ************************************
   task automatic t_regs;
      rdr(12'h000);
      cmp("ctrl", 32'h0000_0004, rd);
      rdr(12'h01c);
      cmp("unmapped resp", 32'h2, {30'h0, rr});
      wr(12'h004, 32'h5);
      cmp("write resp", 32'h0, {30'h0, rr});
      wr(12'h008, 32'h3);
      wr(12'h00c, 32'h14);
      wr(12'h010, 32'ha);
      rdr(12'h00c);
      cmp("mute limit", 32'h14, rd);
      rearm("regs and arm");
   endtask
   task automatic t_mute;
      lvl <= 6'b000000;
      chk(0, 1'b0, 200);
      rearm("intrusion");
      lvl <= 6'b110100;
      repeat (4) @(posedge aclk);
      lvl <= 6'b111100;
      chk(1, 1'b1, 200);
      lvl <= 6'b001100;
      stay(0, 1'b1);
      chk(2, 1'b1, 200);
      chk(0, 1'b0, 0);
      rdr(12'h018);
      cmp("diag", 32'h0000_f003, rd);
      lvl <= 6'b000100;
      stay(2, 1'b1);
      lvl <= 6'b000000;
      chk(2, 1'b0, 200);
      rearm("mute timeout");
   endtask
   task automatic t_errs;
      lvl <= 6'b111000;
      chk(2, 1'b1, 200);
      chk(0, 1'b0, 0);
      lvl <= 6'b110000;
      chk(2, 1'b0, 200);
      rearm("sync timeout");
      lvl <= 6'b100000;
      chk(2, 1'b1, 200);
      lvl <= 6'b110000;
      stay(2, 1'b1);
      lvl <= 6'b000000;
      chk(2, 1'b0, 200);
      rearm("mismatch");
   endtask
   task automatic t_ovr;
      wr(12'h000, 32'h6);
      lvl <= 6'b110100;
      chk(2, 1'b1, 200);
      ovr <= 1'b1;
      chk(0, 1'b1, 200);
      ovr <= 1'b0;
      chk(0, 1'b0, 200);
      lvl <= 6'b110000;
      chk(2, 1'b0, 200);
      $display("test override done");
   endtask
   initial
   begin
      {aresetn, ovr, press, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      block_activate = 1'b1;
      lvl = 6'b110000;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_mute;
      t_errs;
      t_ovr;
      stop_test;
   end
endmodule // light_curtain_muting_monitor_tb_top
